// ### common/hdp_pkg.sv
// Constants and types for the host DMA pointer and FIFO port.
// Assumes a host I/O bus with offsets already relative to the base.
package hdp_pkg;
   localparam logic [11:0] OFS_PTR_HI  = 12'h409;
   localparam logic [11:0] OFS_PTR_LO  = 12'h40a;
   localparam logic [11:0] OFS_VEC_UP  = 12'h40b;
   localparam logic [11:0] OFS_VEC_MID = 12'h40c;
   localparam logic [11:0] OFS_VEC_LO  = 12'h40d;
   localparam logic [11:0] OFS_FIFO_HI = 12'h40e;
   localparam logic [11:0] OFS_FIFO_LO = 12'h40f;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [3:0]  NIB_ZERO    = 4'h0;
   localparam logic [15:0] PTR_STEP    = 16'h0001;
   localparam logic [1:0]  BUF_FULL    = 2'h2;
   localparam logic [1:0]  BUF_EMPTY   = 2'h0;
   localparam logic [1:0]  CNT_ONE     = 2'h1;
   localparam logic        DIR_DL      = 1'b1;

   typedef enum logic [2:0] {
      ENG_IDLE, ENG_WHI, ENG_WLO, ENG_RHI, ENG_RLO, ENG_RC1, ENG_RC2,
      ENG_RPUSH
   } hdp_eng_type;

   typedef struct packed {
      logic [7:0] msb;
      logic [7:0] lsb;
   } hdp_word_type;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        word;
      logic [11:0] addr;
      logic [15:0] wdata;
   } hdp_io_req_type;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } hdp_pb_type;
endpackage : hdp_pkg

// ### core/hdp_port.sv
// Host DMA pointer, vector comparator and two-entry FIFO port.
// Assumes synchronous host strobes held until io_ready, and a packet
// RAM that returns read data the cycle after pb.re.
`timescale 1ns/1ps
module hdp_port
   import hdp_pkg::*;
#(
   parameter int PB_ADDR_W = 16
) (
   // Clock and reset
   input  wire logic           mclk,
   input  wire logic           rst,
   // Host I/O bus
   input  wire hdp_io_req_type io_req,
   output logic                io_ready,
   output logic [15:0]         io_rdata,
   // Host memory address bus
   input  wire logic [19:0]    sa_addr,
   // Control and status from the gate array
   input  wire logic           dma_start,
   input  wire logic           dma_dir,
   output logic                dma_active,
   output logic                mem_window_clr,
   // Packet buffer RAM
   output hdp_pb_type          pb,
   input  wire logic [7:0]     pb_rdata
);

   // Refuse widths the pointer registers cannot serve
   if (PB_ADDR_W != 16) begin : g_chk
      $error("hdp_port: PB_ADDR_W must be 16");
   end

   typedef struct packed {
      logic [7:0]         ptr_hi;
      logic [7:0]         ptr_lo;
      logic [7:0]         vec_up;
      logic [7:0]         vec_mid;
      logic [3:0]         vec_lo;
      hdp_word_type [1:0] ent;
      logic [1:0]         cnt;
      logic               head;
      logic [7:0]         stage;
      hdp_eng_type        eng;
      hdp_word_type       cap;
      hdp_pb_type         pb;
      logic [15:0]        rdata;
      logic               win_clr;
      logic               dip;
   } hdp_state_type;

   hdp_state_type s_r;
   hdp_state_type s_nxt;

   // Pointer join and advance, used by the ENG_WHI, ENG_WLO, ENG_RHI and ENG_RLO states
   function automatic logic [15:0] hdp_ptr(input hdp_state_type s);
      return {s.ptr_hi, s.ptr_lo};
   endfunction : hdp_ptr

   function automatic logic [15:0] hdp_ptr_inc(input hdp_state_type s);
      return hdp_ptr(s) + PTR_STEP;
   endfunction : hdp_ptr_inc

   logic         hit_hi;
   logic         hit_lo;
   logic         dl;
   logic         ul;
   logic         buf_full;
   logic         buf_empty;
   logic         need_push;
   logic         need_pop;
   logic         h_push;
   logic         h_pop;
   logic         e_push;
   logic         e_pop;
   logic         take;
   hdp_word_type head_w;
   hdp_word_type push_w;
   logic [15:0]  p;
   logic [19:0]  vec;

   // Decode and buffer status
   always_comb begin
      hit_hi    = io_req.addr == OFS_FIFO_HI;
      hit_lo    = io_req.addr == OFS_FIFO_LO;
      dl        = dma_dir == DIR_DL;
      ul        = !dl;
      buf_full  = s_r.cnt == BUF_FULL;
      buf_empty = s_r.cnt == BUF_EMPTY;
      head_w    = s_r.ent[s_r.head];
      vec       = {s_r.vec_up, s_r.vec_mid, s_r.vec_lo};
      // Download pushes on low byte or word; upload pops likewise
      need_push = dma_start && dl && io_req.wr
                  && ((hit_hi && io_req.word) || hit_lo);
      need_pop  = dma_start && ul && io_req.rd && (hit_hi || hit_lo);
      // Stall the host instead of dropping a word
      io_ready  = !((need_push && buf_full)
                    || (need_pop && buf_empty));
      take      = (io_req.rd || io_req.wr) && io_ready;
      h_push    = take && need_push;
      h_pop     = take && need_pop && (hit_lo || io_req.word);
   end

   // Next state: host port, pointer engine, buffer and comparator
   always_comb begin
      s_nxt        = s_r;
      s_nxt.pb.we  = 1'b0;
      s_nxt.pb.re  = 1'b0;
      e_push       = 1'b0;
      e_pop        = 1'b0;
      push_w       = s_r.cap;
      p            = hdp_ptr_inc(s_r);

      // Packet side engine
      unique case (s_r.eng)
         ENG_IDLE: begin
            // Download drains even after stop: the flush
            if (dl && !buf_empty) begin
               s_nxt.eng = ENG_WHI;
            end else if (dma_start && ul) begin
               s_nxt.eng = ENG_RHI;
            end
         end
         ENG_WHI: begin
            s_nxt.pb.we    = 1'b1;
            s_nxt.pb.addr  = hdp_ptr(s_r);
            s_nxt.pb.wdata = head_w.msb;
            {s_nxt.ptr_hi, s_nxt.ptr_lo} = p;
            s_nxt.eng      = ENG_WLO;
         end
         ENG_WLO: begin
            s_nxt.pb.we    = 1'b1;
            s_nxt.pb.addr  = hdp_ptr(s_r);
            s_nxt.pb.wdata = head_w.lsb;
            {s_nxt.ptr_hi, s_nxt.ptr_lo} = p;
            e_pop          = 1'b1;
            s_nxt.eng      = ENG_IDLE;
         end
         ENG_RHI, ENG_RLO: begin
            s_nxt.pb.re   = 1'b1;
            s_nxt.pb.addr = hdp_ptr(s_r);
            {s_nxt.ptr_hi, s_nxt.ptr_lo} = p;
            s_nxt.eng = (s_r.eng == ENG_RHI) ? ENG_RLO : ENG_RC1;
         end
         ENG_RC1: begin
            s_nxt.cap.msb = pb_rdata;
            s_nxt.eng     = ENG_RC2;
         end
         ENG_RC2: begin
            s_nxt.cap.lsb = pb_rdata;
            s_nxt.eng     = ENG_RPUSH;
         end
         ENG_RPUSH: begin
            // Wait for room; a stop abandons the prefetched word
            if (!dma_start) begin
               s_nxt.eng = ENG_IDLE;
            end else if (!buf_full) begin
               e_push    = 1'b1;
               s_nxt.eng = ENG_IDLE;
            end
         end
      endcase

      // Host reads: registers, or FIFO bytes when running an upload
      if (take && io_req.rd) begin
         unique case (io_req.addr)
            OFS_PTR_HI:  s_nxt.rdata = {BYTE_ZERO, s_r.ptr_hi};
            OFS_PTR_LO:  s_nxt.rdata = {BYTE_ZERO, s_r.ptr_lo};
            OFS_VEC_UP:  s_nxt.rdata = {BYTE_ZERO, s_r.vec_up};
            OFS_VEC_MID: s_nxt.rdata = {BYTE_ZERO, s_r.vec_mid};
            OFS_VEC_LO:
               s_nxt.rdata = {BYTE_ZERO, s_r.vec_lo, NIB_ZERO};
            OFS_FIFO_HI:
               s_nxt.rdata = !need_pop ? {BYTE_ZERO, BYTE_ZERO}
                           : io_req.word ? {head_w.lsb, head_w.msb}
                           : {BYTE_ZERO, head_w.msb};
            OFS_FIFO_LO:
               s_nxt.rdata = !need_pop ? {BYTE_ZERO, BYTE_ZERO}
                           : {BYTE_ZERO, head_w.lsb};
            default:     s_nxt.rdata = {BYTE_ZERO, BYTE_ZERO};
         endcase
      end

      // Host writes; a pointer write overrides the engine step
      if (take && io_req.wr) begin
         unique case (io_req.addr)
            OFS_PTR_HI:  s_nxt.ptr_hi  = io_req.wdata[7:0];
            OFS_PTR_LO:  s_nxt.ptr_lo  = io_req.wdata[7:0];
            OFS_VEC_UP:  s_nxt.vec_up  = io_req.wdata[7:0];
            OFS_VEC_MID: s_nxt.vec_mid = io_req.wdata[7:0];
            OFS_VEC_LO:  s_nxt.vec_lo  = io_req.wdata[7:4];
            OFS_FIFO_HI: begin
               // Byte write parks the MSB until the LSB arrives
               if (dma_start && dl && !io_req.word) begin
                  s_nxt.stage = io_req.wdata[7:0];
               end
            end
            default: ;
         endcase
      end
      if (h_push) begin
         push_w = hit_lo ? {s_r.stage, io_req.wdata[7:0]}
                : {io_req.wdata[7:0], io_req.wdata[15:8]};
      end

      // Two-entry buffer; pushes and pops are direction exclusive
      if ((h_push || e_push) && !buf_full) begin
         s_nxt.ent[s_r.head ^ (s_r.cnt == CNT_ONE)] = push_w;
      end
      s_nxt.cnt = s_r.cnt + 2'((h_push || e_push) && !buf_full)
                          - 2'(h_pop || e_pop);
      if (h_pop || e_pop) begin
         s_nxt.head = !s_r.head;
      end
      // Upload data is invalid once the DMA is stopped
      if (!dma_start && ul) begin
         s_nxt.cnt = BUF_EMPTY;
      end

      // Comparator and status
      s_nxt.win_clr = sa_addr == vec;
      s_nxt.dip = dma_start
                  || (dl && (!buf_empty || s_r.eng != ENG_IDLE));
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign io_rdata       = s_r.rdata;
   assign pb             = s_r.pb;
   assign mem_window_clr = s_r.win_clr;
   assign dma_active     = s_r.dip;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Readback only holds while the engine is parked and cannot step
   sequence ptr_hi_wr;
      io_req.wr && io_ready && io_req.addr == OFS_PTR_HI
      && s_r.eng == ENG_IDLE && !dma_start && buf_empty;
   endsequence
   sequence ptr_lo_wr;
      io_req.wr && io_ready && io_req.addr == OFS_PTR_LO
      && s_r.eng == ENG_IDLE && !dma_start && buf_empty;
   endsequence
   sequence read_hi;
      io_req.rd && io_ready && io_req.addr == OFS_PTR_HI;
   endsequence
   sequence read_lo;
      io_req.rd && io_ready && io_req.addr == OFS_PTR_LO;
   endsequence
   sequence byte_pair;
      $rose(pb.we) ##1 pb.we;
   endsequence

   a_ptr_hi_back: assert property (
      ptr_hi_wr ##1 !io_req.wr ##1 read_hi
      |=> io_rdata[7:0] == $past(io_req.wdata[7:0], 3))
      else $error("pointer high readback wrong");
   a_ptr_lo_back: assert property (
      ptr_lo_wr ##1 !io_req.wr ##1 read_lo
      |=> io_rdata[7:0] == $past(io_req.wdata[7:0], 3))
      else $error("pointer low readback wrong");
   a_ptr_step: assert property (
      byte_pair |-> pb.addr == $past(pb.addr) + PTR_STEP)
      else $error("pointer did not advance by one");
   a_msb_first: assert property (
      $rose(pb.we) |-> pb.wdata == $past(head_w.msb))
      else $error("MSB not written first");
   a_vec_lo_read: assert property (
      io_req.rd && io_ready && io_req.addr == OFS_VEC_LO
      |=> io_rdata[3:0] == NIB_ZERO)
      else $error("unused vector bits not zero");
   a_vec_match: assert property (
      sa_addr == vec && !(io_req.wr && io_ready) |=> mem_window_clr)
      else $error("vector match missed");
   a_flush_dip: assert property (
      !dma_start && dl && !buf_empty |=> dma_active)
      else $error("active flag dropped during flush");
   a_stop_zero: assert property (
      !dma_start && io_req.rd && (hit_hi || hit_lo)
      |=> io_rdata == 16'h0000)
      else $error("FIFO read while stopped not zero");
   a_dl_drain: assert property (
      h_push && dl |-> ##[1:8] pb.we)
      else $error("download word never written");
   a_ul_fill: assert property (
      dma_start && ul && s_r.eng == ENG_IDLE |-> ##[1:3] pb.re)
      else $error("upload prefetch did not start");
   a_win_miss: assert property (
      sa_addr != vec |=> !mem_window_clr)
      else $error("window cleared without a match");
   a_dip_drop: assert property (
      !dma_start && buf_empty && s_r.eng == ENG_IDLE |=> !dma_active)
      else $error("active flag stuck after flush");
   a_stop_ignore: assert property (
      !dma_start && dl && buf_empty |=> buf_empty)
      else $error("stopped download buffered data");

endmodule : hdp_port

// ### verification/hdp_pb_model.sv
// Behavioural packet buffer RAM facing the DMA side of the port.
// Assumes one strobe per cycle; never inserts wait states.
`timescale 1ns/1ps
module hdp_pb_model
   import hdp_pkg::*;
(
   // Clock
   input  wire logic       mclk,
   // Strobes and data from the port
   input  wire hdp_pb_type pb,
   output logic [7:0]      pb_rdata
);
   logic [7:0] mem [0:65535];

   // Known pattern so upload data is checkable
   initial begin
      for (int i = 0; i < 65536; i++)
         mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
   end

   // Read data valid one cycle only; churns otherwise to expose misuse
   always @(posedge mclk) begin
      if (pb.we)
         mem[pb.addr] <= pb.wdata;
      if (pb.re)
         pb_rdata <= mem[pb.addr];
      else
         pb_rdata <= ~pb_rdata;
   end
endmodule : hdp_pb_model

// ### verification/tb.sv
// Self-checking bench for the host DMA pointer and FIFO port.
// Assumes the packet RAM model; assertions sit in the design.
`timescale 1ns/1ps
module tb
   import hdp_pkg::*;
();
   typedef struct packed {
      logic [11:0] a;
      logic [7:0]  d;
      logic [7:0]  e;
   } hdp_row_type;
   // Offset, value written, value read back
   hdp_row_type    rows [6] = '{
      '{12'h409, 8'h3f, 8'h3f}, '{12'h40a, 8'hff, 8'hff},
      '{12'h40b, 8'ha5, 8'ha5}, '{12'h40c, 8'h3c, 8'h3c},
      '{12'h40d, 8'hb7, 8'hb0}, '{12'h408, 8'h55, 8'h00}};
   logic           mclk = 1'b0;
   logic           rst = 1'b1;
   hdp_io_req_type io_req = '0;
   logic           io_ready;
   logic [15:0]    io_rdata;
   logic [15:0]    rd;
   logic [15:0]    pa;
   logic [15:0]    ex;
   logic [19:0]    sa_addr = 20'hfffff;
   logic           dma_start = 1'b0;
   logic           dma_dir = 1'b0;
   logic           dma_active;
   logic           mem_window_clr;
   logic           stalled = 1'b0;
   hdp_pb_type     pb;
   logic [7:0]     pb_rdata;
   int             n_fail = 0;
   int             checked = 0;

   // 100 MHz clock
   always #5 mclk = ~mclk;

   hdp_port #(.PB_ADDR_W(16)) dut (
      .mclk(mclk), .rst(rst), .io_req(io_req), .io_ready(io_ready),
      .io_rdata(io_rdata), .sa_addr(sa_addr), .dma_start(dma_start),
      .dma_dir(dma_dir), .dma_active(dma_active),
      .mem_window_clr(mem_window_clr), .pb(pb), .pb_rdata(pb_rdata));
   hdp_pb_model ram (.mclk(mclk), .pb(pb), .pb_rdata(pb_rdata));

   function automatic logic [7:0] pat(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction : pat

   // Two packet RAM bytes, MSB at the lower address
   function automatic logic [15:0] ram_word(logic [15:0] a);
      return {ram.mem[a], ram.mem[a + 16'h1]};
   endfunction : ram_word

   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic done(string nm);
      $display("test %s finished", nm);
   endtask : done

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // Host access held until ready; cnt > 1 streams words back to back
   task automatic io(logic w, logic wd, logic [11:0] a, logic [15:0] d,
                     int cnt = 1);
      int n;
      @(posedge mclk);
      for (int k = 0; k < cnt; k++) begin
         io_req <= '{!w, w, wd, a, d + 16'(k) * 16'h0101};
         n = 0;
         do begin
            @(negedge mclk);
            n++;
         end while (io_ready !== 1'b1 && n < 100);
         if (n > 1)
            stalled = 1'b1;
         if (n >= 100)
            n_fail++;
         @(posedge mclk);
      end
      io_req <= '0;
      @(negedge mclk);
      rd = io_rdata;
   endtask : io

   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         io(1, 0, rows[i].a, {8'h00, rows[i].d});
         io(0, 0, rows[i].a, 16'h0);
         chk("register", {8'h00, rows[i].e}, rd);
      end
      done("registers");
      // Only the exact 20-bit match may clear the window
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         sa_addr <= (i == 0) ? 20'ha53cb : (i == 1) ? 20'ha53ca : 20'h253cb;
         @(posedge mclk);
         @(negedge mclk);
         chk("window", {15'h0, i == 0}, {15'h0, mem_window_clr});
      end
      done("vector");
      io(1, 0, 12'h409, 16'h0020);
      io(1, 0, 12'h40a, 16'h00fe);
      @(posedge mclk);
      dma_dir <= 1'b1;
      dma_start <= 1'b1;
      io(1, 0, 12'h40e, 16'h0056);
      io(1, 0, 12'h40f, 16'h0078);
      io(1, 1, 12'h40e, 16'h3412, 5);
      @(posedge mclk);
      dma_start <= 1'b0;
      @(negedge mclk);
      chk("flushing", 16'h1, {15'h0, dma_active});
      // Pointers are left alone until the flush has ended
      for (int n = 0; n < 60 && dma_active !== 1'b0; n++)
         @(negedge mclk);
      chk("flushed", 16'h0, {15'h0, dma_active});
      chk("stall", 16'h1, {15'h0, stalled});
      chk("ram", 16'h5678, ram_word(16'h20fe));
      for (int k = 0; k < 5; k++) begin
         pa = 16'h2100 + 16'(2 * k);
         ex = {8'h12 + 8'(k), 8'h34 + 8'(k)};
         chk("ram", ex, ram_word(pa));
      end
      io(0, 0, 12'h409, 16'h0);
      chk("ptr hi", 16'h0021, rd);
      io(0, 0, 12'h40a, 16'h0);
      chk("ptr lo", 16'h000a, rd);
      io(1, 1, 12'h40e, 16'hc3c3);
      repeat (4) @(negedge mclk);
      pa = 16'h210a;
      chk("stopped", {8'h00, pat(pa)}, {8'h00, ram.mem[pa]});
      done("download");
      io(1, 0, 12'h409, 16'h0023);
      io(1, 0, 12'h40a, 16'h0000);
      @(posedge mclk);
      dma_dir <= 1'b0;
      dma_start <= 1'b1;
      io(0, 1, 12'h40e, 16'h0);
      chk("up word", {pat(16'h2301), pat(16'h2300)}, rd);
      io(0, 0, 12'h40e, 16'h0);
      chk("up msb", {8'h00, pat(16'h2302)}, rd);
      io(0, 0, 12'h40f, 16'h0);
      chk("up lsb", {8'h00, pat(16'h2303)}, rd);
      io(0, 1, 12'h40e, 16'h0);
      chk("up word2", {pat(16'h2305), pat(16'h2304)}, rd);
      @(posedge mclk);
      dma_start <= 1'b0;
      io(0, 0, 12'h40e, 16'h0);
      chk("up stopped", 16'h0, rd);
      done("upload");
      // Mid-run reset must clear live pointers, vector and status
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         io(0, 0, 12'h409 + 12'(i), 16'h0);
         chk("reset reg", 16'h0, rd);
      end
      chk("idle active", 16'h0, {15'h0, dma_active});
      done("reset");
      print_verdict();
   end

   // Run is about 130 cycles; 20000 cycles means a hang
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
endmodule : tb
